// [hw/acwd_pkg.sv]
// acwd_pkg: register map, field positions and reset values of the calibration/window block
package acwd_pkg;

  // ----------------------------------------------------------------
  // register addresses on the special-function-register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CALIB_POINTER    = 8'hBA;
  localparam logic [7:0] ADDR_CALIB_COEF_DATA  = 8'hBB;
  localparam logic [7:0] ADDR_CAL_CONFIG0      = 8'hBC;
  localparam logic [7:0] ADDR_CAL_CONFIG1      = 8'hBD;
  localparam logic [7:0] ADDR_INPUT_MUX_SELECT = 8'hBE;
  localparam logic [7:0] ADDR_WINDOW_GT_LOW    = 8'hC4;
  localparam logic [7:0] ADDR_WINDOW_GT_HIGH   = 8'hC5;
  localparam logic [7:0] ADDR_WINDOW_LT_LOW    = 8'hC6;
  localparam logic [7:0] ADDR_WINDOW_LT_HIGH   = 8'hC7;
  localparam logic [7:0] ADDR_CONV0_CONTROL    = 8'hE8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PTR_AUTO_ADVANCE_BIT = 7;
  localparam int PTR_CONV_SELECT_BIT  = 6;
  localparam int PTR_LOCATION_W       = 6;
  localparam int CAL_OFFSET_BIT       = 0;
  localparam int CAL_GAIN_BIT         = 1;
  localparam int CAL_LINEARITY_BIT    = 2;
  localparam int CAL_START_W          = 3;
  localparam int MUX_DIFF_BIT         = 6;
  localparam int CTRL_WINDOW_FLAG_BIT = 1;

  // ----------------------------------------------------------------
  // coefficient store layout
  // ----------------------------------------------------------------
  localparam int OFFSET_COEF_W = 14;
  localparam int GAIN_COEF_W   = 13;
  localparam logic [5:0] LOC_OFFSET_LOW  = 6'h13;
  localparam logic [5:0] LOC_OFFSET_HIGH = 6'h14;
  localparam logic [5:0] LOC_GAIN_LOW    = 6'h15;
  localparam logic [5:0] LOC_GAIN_HIGH   = 6'h16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_CALIB_POINTER = 8'hD7;
  localparam logic [7:0]  RST_BYTE_REG      = 8'h00;
  localparam logic [13:0] RST_OFFSET_COEF   = 14'h2000;
  localparam logic [12:0] RST_GAIN_COEF     = 13'h1000;
  localparam logic [2:0]  RST_CAL_START     = 3'h0;
  localparam logic        RST_WINDOW_FLAG   = 1'b0;

endpackage : acwd_pkg

// [hw/acwd_top.sv]
// acwd_top: coefficient store access and converter-0 window comparator
`timescale 1ns/1ps
// How it works
// - offset coefficient 14 bits, 0x2000 neutral
// - gain coefficient 13 bits, 0x1000 neutral
// - auto-advance bumps pointer after data access
// - pointer bit 6 picks converter store
// - pointer bits 5-0 address the location
// - data register reads/writes pointed byte
// - compare every converter-0 result, set flag
// - flag usable as interrupt or polled
// - limits built from high and low bytes
// - single-ended or differential result compared
// - lt above gt: flag inside window
// - lt below gt: flag outside window
// - differential compares signed two's complement
// - evaluate at end of conversion only
// - hardware clears calibration start when done
module acwd_top #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  // converter-0 result
  input  wire logic              conv0_eoc,
  input  wire logic [DATA_W-1:0] conv0_data,
  // calibration engines
  input  wire logic              cal_done0,
  input  wire logic              cal_done1,
  output logic      [2:0]        cal_start0,
  output logic      [2:0]        cal_start1,
  // coefficients toward the analog path
  output logic      [13:0]       offset_coef0,
  output logic      [12:0]       gain_coef0,
  output logic      [13:0]       offset_coef1,
  output logic      [12:0]       gain_coef1,
  // mode and window status
  output logic                   diff_mode,
  output logic                   window_compare_flag
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a > b, signed or unsigned depending on mode
  function automatic logic above(input logic [DATA_W-1:0] a,
                                 input logic [DATA_W-1:0] b,
                                 input logic              sgn);
    logic r;
    r = 1'b0;
    if (sgn) begin
      r = $signed(a) > $signed(b);
    end else begin
      r = a > b;
    end
    return r;
  endfunction : above

  function automatic logic wr_hit(input logic [7:0] a);
    return sfr_wr && (sfr_addr == a);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] calib_pointer_reg;
  logic [7:0] calib_pointer_next;
  logic [7:0] coef_mem_reg  [0:127];
  logic [7:0] coef_mem_next [0:127];
  logic [7:0] gt_low_reg;
  logic [7:0] gt_low_next;
  logic [7:0] gt_high_reg;
  logic [7:0] gt_high_next;
  logic [7:0] lt_low_reg;
  logic [7:0] lt_low_next;
  logic [7:0] lt_high_reg;
  logic [7:0] lt_high_next;
  logic [7:0] input_mux_select_reg;
  logic [7:0] input_mux_select_next;
  logic [2:0] cal_start0_reg;
  logic [2:0] cal_start0_next;
  logic [2:0] cal_start1_reg;
  logic [2:0] cal_start1_next;
  logic       window_flag_reg;
  logic       window_flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ----------------------------------------------------------------
  // derived decode
  // ----------------------------------------------------------------
  logic              coef_access;
  logic [6:0]        coef_index;
  logic [DATA_W-1:0] gt_limit;
  logic [DATA_W-1:0] lt_limit;
  logic              is_diff;
  logic              hit;

  // store selected by pointer bit 6
  assign coef_index = {calib_pointer_reg[acwd_pkg::PTR_CONV_SELECT_BIT],
                       calib_pointer_reg[acwd_pkg::PTR_LOCATION_W-1:0]};
  assign coef_access = (sfr_wr || sfr_rd) && (sfr_addr == acwd_pkg::ADDR_CALIB_COEF_DATA);
  assign gt_limit = DATA_W'({gt_high_reg, gt_low_reg});
  assign lt_limit = DATA_W'({lt_high_reg, lt_low_reg});
  assign is_diff  = input_mux_select_reg[acwd_pkg::MUX_DIFF_BIT];

  // ----------------------------------------------------------------
  // window decision
  // ----------------------------------------------------------------
  // limits equal falls to the outside test, which can never be met by both
  always_comb begin
    hit = 1'b0;
    if (above(lt_limit, gt_limit, is_diff)) begin
      hit = above(lt_limit, conv0_data, is_diff) && above(conv0_data, gt_limit, is_diff);
    end else begin
      hit = above(conv0_data, gt_limit, is_diff) || above(lt_limit, conv0_data, is_diff);
    end
  end

  // ----------------------------------------------------------------
  // pointer and coefficient store
  // ----------------------------------------------------------------
  always_comb begin
    calib_pointer_next = calib_pointer_reg;
    coef_mem_next      = coef_mem_reg;
    if (wr_hit(acwd_pkg::ADDR_CALIB_POINTER)) begin
      calib_pointer_next = sfr_wdata;
    end else if (coef_access) begin
      if (sfr_wr) begin
        coef_mem_next[coef_index] = sfr_wdata;
      end
      if (calib_pointer_reg[acwd_pkg::PTR_AUTO_ADVANCE_BIT]) begin
        calib_pointer_next[acwd_pkg::PTR_LOCATION_W-1:0] =
          calib_pointer_reg[acwd_pkg::PTR_LOCATION_W-1:0] + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // limit, mode and calibration control registers
  // ----------------------------------------------------------------
  always_comb begin
    gt_low_next           = gt_low_reg;
    gt_high_next          = gt_high_reg;
    lt_low_next           = lt_low_reg;
    lt_high_next          = lt_high_reg;
    input_mux_select_next = input_mux_select_reg;
    // engine finishing clears its start bits
    cal_start0_next       = cal_done0 ? 3'h0 : cal_start0_reg;
    cal_start1_next       = cal_done1 ? 3'h0 : cal_start1_reg;
    if (wr_hit(acwd_pkg::ADDR_WINDOW_GT_LOW)) begin
      gt_low_next = sfr_wdata;
    end else if (wr_hit(acwd_pkg::ADDR_WINDOW_GT_HIGH)) begin
      gt_high_next = sfr_wdata;
    end else if (wr_hit(acwd_pkg::ADDR_WINDOW_LT_LOW)) begin
      lt_low_next = sfr_wdata;
    end else if (wr_hit(acwd_pkg::ADDR_WINDOW_LT_HIGH)) begin
      lt_high_next = sfr_wdata;
    end else if (wr_hit(acwd_pkg::ADDR_INPUT_MUX_SELECT)) begin
      input_mux_select_next = sfr_wdata;
    end else if (wr_hit(acwd_pkg::ADDR_CAL_CONFIG0)) begin
      cal_start0_next = sfr_wdata[acwd_pkg::CAL_START_W-1:0];
    end else if (wr_hit(acwd_pkg::ADDR_CAL_CONFIG1)) begin
      cal_start1_next = sfr_wdata[acwd_pkg::CAL_START_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // window flag
  // ----------------------------------------------------------------
  always_comb begin
    window_flag_next = window_flag_reg;
    if (wr_hit(acwd_pkg::ADDR_CONV0_CONTROL) &&
        !sfr_wdata[acwd_pkg::CTRL_WINDOW_FLAG_BIT]) begin
      window_flag_next = 1'b0;
    end
    // judged only at end of conversion
    // hardware sets, set wins over clear
    if (conv0_eoc && hit) begin
      window_flag_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // data appears one cycle after the read strobe; unmapped reads give zero
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd) begin
      if (sfr_addr == acwd_pkg::ADDR_CALIB_POINTER) begin
        rdata_next = calib_pointer_reg;
      end else if (sfr_addr == acwd_pkg::ADDR_CALIB_COEF_DATA) begin
        rdata_next = coef_mem_reg[coef_index];
      end else if (sfr_addr == acwd_pkg::ADDR_CAL_CONFIG0) begin
        rdata_next = {5'h00, cal_start0_reg};
      end else if (sfr_addr == acwd_pkg::ADDR_CAL_CONFIG1) begin
        rdata_next = {5'h00, cal_start1_reg};
      end else if (sfr_addr == acwd_pkg::ADDR_INPUT_MUX_SELECT) begin
        rdata_next = input_mux_select_reg;
      end else if (sfr_addr == acwd_pkg::ADDR_WINDOW_GT_LOW) begin
        rdata_next = gt_low_reg;
      end else if (sfr_addr == acwd_pkg::ADDR_WINDOW_GT_HIGH) begin
        rdata_next = gt_high_reg;
      end else if (sfr_addr == acwd_pkg::ADDR_WINDOW_LT_LOW) begin
        rdata_next = lt_low_reg;
      end else if (sfr_addr == acwd_pkg::ADDR_WINDOW_LT_HIGH) begin
        rdata_next = lt_high_reg;
      end else if (sfr_addr == acwd_pkg::ADDR_CONV0_CONTROL) begin
        rdata_next = {6'h00, window_flag_reg, 1'b0};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      calib_pointer_reg    <= acwd_pkg::RST_CALIB_POINTER;
      gt_low_reg           <= acwd_pkg::RST_BYTE_REG;
      gt_high_reg          <= acwd_pkg::RST_BYTE_REG;
      lt_low_reg           <= acwd_pkg::RST_BYTE_REG;
      lt_high_reg          <= acwd_pkg::RST_BYTE_REG;
      input_mux_select_reg <= acwd_pkg::RST_BYTE_REG;
      cal_start0_reg       <= acwd_pkg::RST_CAL_START;
      cal_start1_reg       <= acwd_pkg::RST_CAL_START;
      window_flag_reg      <= acwd_pkg::RST_WINDOW_FLAG;
      rdata_reg            <= acwd_pkg::RST_BYTE_REG;
      for (int i = 0; i < 128; i++) begin
        coef_mem_reg[i] <= acwd_pkg::RST_BYTE_REG;
      end
      for (int c = 0; c < 2; c++) begin
        coef_mem_reg[{c[0], acwd_pkg::LOC_OFFSET_LOW}]  <= acwd_pkg::RST_OFFSET_COEF[7:0];
        coef_mem_reg[{c[0], acwd_pkg::LOC_OFFSET_HIGH}] <=
          {2'h0, acwd_pkg::RST_OFFSET_COEF[13:8]};
        coef_mem_reg[{c[0], acwd_pkg::LOC_GAIN_LOW}]    <= acwd_pkg::RST_GAIN_COEF[7:0];
        coef_mem_reg[{c[0], acwd_pkg::LOC_GAIN_HIGH}]   <=
          {3'h0, acwd_pkg::RST_GAIN_COEF[12:8]};
      end
    end else begin
      calib_pointer_reg    <= calib_pointer_next;
      coef_mem_reg         <= coef_mem_next;
      gt_low_reg           <= gt_low_next;
      gt_high_reg          <= gt_high_next;
      lt_low_reg           <= lt_low_next;
      lt_high_reg          <= lt_high_next;
      input_mux_select_reg <= input_mux_select_next;
      cal_start0_reg       <= cal_start0_next;
      cal_start1_reg       <= cal_start1_next;
      window_flag_reg      <= window_flag_next;
      rdata_reg            <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // 14-bit offset assembled from two bytes
  assign offset_coef0 = {coef_mem_reg[{1'b0, acwd_pkg::LOC_OFFSET_HIGH}][5:0],
                         coef_mem_reg[{1'b0, acwd_pkg::LOC_OFFSET_LOW}]};
  assign offset_coef1 = {coef_mem_reg[{1'b1, acwd_pkg::LOC_OFFSET_HIGH}][5:0],
                         coef_mem_reg[{1'b1, acwd_pkg::LOC_OFFSET_LOW}]};
  // 13-bit gain assembled from two bytes
  assign gain_coef0   = {coef_mem_reg[{1'b0, acwd_pkg::LOC_GAIN_HIGH}][4:0],
                         coef_mem_reg[{1'b0, acwd_pkg::LOC_GAIN_LOW}]};
  assign gain_coef1   = {coef_mem_reg[{1'b1, acwd_pkg::LOC_GAIN_HIGH}][4:0],
                         coef_mem_reg[{1'b1, acwd_pkg::LOC_GAIN_LOW}]};
  // mode bit chooses the compare arithmetic
  assign diff_mode           = input_mux_select_reg[acwd_pkg::MUX_DIFF_BIT];
  assign window_compare_flag = window_flag_reg;
  assign cal_start0          = cal_start0_reg;
  assign cal_start1          = cal_start1_reg;
  assign sfr_rdata           = rdata_reg;

endmodule : acwd_top

// [dv/acwd_checker.sv]
// acwd_checker: port-level assertions for the window comparator, calibration start bits, mode bit and read port
`timescale 1ns/1ps
module acwd_checker #(
  parameter int DATA_W = 16
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [7:0]        sfr_addr,
  input wire logic              sfr_wr,
  input wire logic              sfr_rd,
  input wire logic [7:0]        sfr_wdata,
  input wire logic [7:0]        sfr_rdata,
  input wire logic              conv0_eoc,
  input wire logic [DATA_W-1:0] conv0_data,
  input wire logic              cal_done0,
  input wire logic [2:0]        cal_start0,
  input wire logic              diff_mode,
  input wire logic              window_compare_flag
);
  // ----------------------------------------------------------------
  // limit mirror, rebuilt from the byte writes
  // ----------------------------------------------------------------
  logic [15:0] gt_reg, gt_next, lt_reg, lt_next;
  logic        clr;
  logic        hit;
  always_comb begin
    gt_next = gt_reg;
    lt_next = lt_reg;
    if (sfr_wr && sfr_addr == 8'hC4) gt_next[7:0] = sfr_wdata;
    if (sfr_wr && sfr_addr == 8'hC5) gt_next[15:8] = sfr_wdata;
    if (sfr_wr && sfr_addr == 8'hC6) lt_next[7:0] = sfr_wdata;
    if (sfr_wr && sfr_addr == 8'hC7) lt_next[15:8] = sfr_wdata;
  end
  always_ff @(posedge clk) begin
    gt_reg <= rst_n ? gt_next : 16'h0000;
    lt_reg <= rst_n ? lt_next : 16'h0000;
  end
  // flipping the sign bit turns a signed compare into an unsigned one
  function automatic logic hit_f(input logic [15:0] d, lt, gt, input logic s);
    logic [15:0] m;
    m = {s, 15'h0000};
    hit_f = ((lt ^ m) > (gt ^ m)) ? (((d ^ m) > (gt ^ m)) && ((d ^ m) < (lt ^ m)))
                                  : (((d ^ m) > (gt ^ m)) || ((d ^ m) < (lt ^ m)));
  endfunction : hit_f
  assign hit = conv0_eoc && hit_f(conv0_data[15:0], lt_reg, gt_reg, diff_mode);
  assign clr = sfr_wr && sfr_addr == 8'hE8 && !sfr_wdata[1];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_flag_on_hit: assert property (hit |=> window_compare_flag)
    else $error("window flag missed a qualifying result");
  chk_flag_no_cause: assert property (!window_compare_flag && !hit
    |=> !window_compare_flag)
    else $error("window flag rose without a qualifying result");
  chk_flag_sticky: assert property (window_compare_flag && !clr |=> window_compare_flag)
    else $error("window flag dropped without a clearing write");
  chk_flag_clear: assert property (clr && !hit |=> !window_compare_flag)
    else $error("window flag survived a clearing write");
  chk_cal_done_clr: assert property (cal_done0 && !(sfr_wr && sfr_addr == 8'hBC)
    |=> cal_start0 == 3'h0)
    else $error("calibration start bits not cleared on done");
  chk_cal_set: assert property (sfr_wr && sfr_addr == 8'hBC && sfr_wdata[0]
    |=> cal_start0[0])
    else $error("offset calibration start not set by write");
  chk_rdata_stand: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  chk_diff_mode_set: assert property (sfr_wr && sfr_addr == 8'hBE |=>
    diff_mode == $past(sfr_wdata[6]))
    else $error("differential mode does not follow mux write");
endmodule : acwd_checker

bind acwd_top acwd_checker #(.DATA_W(DATA_W)) i_chk (
  .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv0_eoc(conv0_eoc),
  .conv0_data(conv0_data), .cal_done0(cal_done0), .cal_start0(cal_start0),
  .diff_mode(diff_mode), .window_compare_flag(window_compare_flag)
);

// [dv/acwd_top_tb.sv]
// acwd_top_tb: register-level bench of the coefficient pointer and window comparator
`timescale 1ns/1ps
module acwd_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        conv0_eoc = 1'b0;
  logic [15:0] conv0_data = 16'h0000;
  logic        cal_done0 = 1'b0;
  logic        cal_done1 = 1'b0;
  logic [7:0]  sfr_rdata;
  logic [2:0]  cal_start0, cal_start1;
  logic [13:0] offset_coef0, offset_coef1;
  logic [12:0] gain_coef0, gain_coef1;
  logic        diff_mode, window_compare_flag;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  // mode, less-than, greater-than, data word, expected flag
  logic [49:0] win_tab [0:11] = '{
    {1'b0, 16'h2000, 16'h1000, 16'h1800, 1'b1}, {1'b0, 16'h2000, 16'h1000, 16'h1000, 1'b0},
    {1'b0, 16'h1000, 16'h2000, 16'h0800, 1'b1}, {1'b0, 16'h1000, 16'h2000, 16'h2800, 1'b1},
    {1'b0, 16'h1000, 16'h2000, 16'h1800, 1'b0}, {1'b1, 16'h1000, 16'hFFFF, 16'h0000, 1'b1},
    {1'b1, 16'h1000, 16'hFFFF, 16'hFFFF, 1'b0}, {1'b1, 16'h1000, 16'hFFFF, 16'h1000, 1'b0},
    {1'b1, 16'hFFFF, 16'h1000, 16'hFFFE, 1'b1}, {1'b1, 16'hFFFF, 16'h1000, 16'h1001, 1'b1},
    {1'b1, 16'hFFFF, 16'h1000, 16'h0000, 1'b0}, {1'b0, 16'h2000, 16'h1000, 16'h2000, 1'b0}};

  always #4 clk = ~clk;

  acwd_top i_dut (
    .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv0_eoc(conv0_eoc),
    .conv0_data(conv0_data), .cal_done0(cal_done0), .cal_done1(cal_done1),
    .cal_start0(cal_start0), .cal_start1(cal_start1), .offset_coef0(offset_coef0),
    .gain_coef0(gain_coef0), .offset_coef1(offset_coef1), .gain_coef1(gain_coef1),
    .diff_mode(diff_mode), .window_compare_flag(window_compare_flag)
  );

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk) #1;
    sfr_wr = 1'b0;
  endtask : wr
  // read data is registered, so it is looked at one edge after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk) #1;
    sfr_rd = 1'b0;
    check(sfr_rdata, exp);
  endtask : rd_chk
  task automatic eoc(input logic [15:0] d, input logic clr);
    @(posedge clk) #1;
    conv0_data = d;
    conv0_eoc = 1'b1;
    sfr_addr = 8'hE8;
    sfr_wdata = 8'h00;
    sfr_wr = clr;
    @(posedge clk) #1;
    conv0_eoc = 1'b0;
    sfr_wr = 1'b0;
  endtask : eoc
  task automatic done(input logic sel);
    @(posedge clk) #1;
    cal_done0 = ~sel;
    cal_done1 = sel;
    @(posedge clk) #1;
    cal_done0 = 1'b0;
    cal_done1 = 1'b0;
  endtask : done
  task automatic tally_and_finish;
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic        md;
    logic        ex;
    logic [15:0] lt, gt, dw;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    rd_chk(8'hBA, 8'hD7);
    rd_chk(8'hC7, 8'h00);
    check(offset_coef0, 16'h2000);
    check(gain_coef1, 16'h1000);
    wr(8'hBA, 8'h93);
    wr(8'hBB, 8'h34);
    wr(8'hBB, 8'h12);
    wr(8'hBB, 8'h78);
    wr(8'hBB, 8'h1F);
    check(offset_coef0, 16'h1234);
    check(gain_coef0, 16'h1F78);
    rd_chk(8'hBA, 8'h97);
    wr(8'hBA, 8'hD3);
    wr(8'hBB, 8'hFF);
    wr(8'hBB, 8'h3F);
    check(offset_coef1, 16'h3FFF);
    check(offset_coef0, 16'h1234);
    wr(8'hBA, 8'h13);
    rd_chk(8'hBB, 8'h34);
    rd_chk(8'hBB, 8'h34);
    rd_chk(8'hBA, 8'h13);
    wr(8'hBA, 8'hFF);
    wr(8'hBB, 8'hA5);
    rd_chk(8'hBA, 8'hC0);
    wr(8'hBA, 8'h3F);
    rd_chk(8'hBB, 8'h00);
    rd_chk(8'h00, 8'h00);
    wr(8'hC5, 8'hAB);
    rd_chk(8'hC5, 8'hAB);
    foreach (win_tab[i]) begin
      {md, lt, gt, dw, ex} = win_tab[i];
      wr(8'hBE, {1'b0, md, 6'h00});
      wr(8'hC7, lt[15:8]);
      wr(8'hC6, lt[7:0]);
      wr(8'hC5, gt[15:8]);
      wr(8'hC4, gt[7:0]);
      wr(8'hE8, 8'h00);
      eoc(dw, 1'b0);
      check(diff_mode, md);
      check(window_compare_flag, ex);
    end
    eoc(16'h1800, 1'b0);
    eoc(16'h2000, 1'b0);
    check(window_compare_flag, 1'b1);
    rd_chk(8'hE8, 8'h02);
    wr(8'hE8, 8'h02);
    check(window_compare_flag, 1'b1);
    wr(8'hE8, 8'h00);
    check(window_compare_flag, 1'b0);
    eoc(16'h1800, 1'b1);
    check(window_compare_flag, 1'b1);
    wr(8'hBC, 8'h07);
    check(cal_start0, 16'h0007);
    done(1'b0);
    check(cal_start0, 16'h0000);
    wr(8'hBD, 8'h02);
    check(cal_start1, 16'h0002);
    done(1'b1);
    check(cal_start1, 16'h0000);
    tally_and_finish();
  end
endmodule : acwd_top_tb
